// *** inc/sfl_pkg.sv ***
// Notes on behaviour
// - Parity error sets sticky flag, interrupts
// - Store into full FIFO sets sticky overrun
// - Data-available flag while FIFO holds data
// - Data-available held off while rx closed
// - Rx DMA mode acknowledges rx closed itself
// - Rx half flag at sixteen bytes or more
// - Rx buffer close sets sticky closed flag
// - Rx close latches upper status, DMA copies
// - HDLC frame status latched, DMA copies
// - Live flag while rx FIFO full
// - Carrier or ring change sets sticky flag
// - Set-ready or clear-send change sets flag
// - Tx ready while FIFO accepts a write
// - Tx ready held off while tx closed
// - Tx half flag at sixteen free bytes
// - Tx close sticky, auto-acknowledged in DMA
// - Tx closed only in HDLC, latches status
// - Tx empty reports FIFO only
// - Byte count code: 00 means four bytes
package sfl_pkg;

   // ************************************************************
   // Register map
   // ************************************************************
   localparam int ADDR_W = 12;
   localparam logic [11:0] CTRL_OFF = 12'h000;
   localparam logic [11:0] STATUS_A_OFF = 12'h008;
   localparam logic [11:0] STATUS_B_OFF = 12'h00C;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

   // ************************************************************
   // Control register fields
   // ************************************************************
   localparam int CTL_IRQ_EN = 0;
   localparam int CTL_MODE_LO = 1;
   localparam int CTL_RX_DMA = 3;
   localparam int CTL_TX_DMA = 4;

   // ************************************************************
   // Status register A fields
   // ************************************************************
   localparam int POS_LINE_STAT_LO = 26;
   localparam int POS_BYTE_CNT_LO = 20;
   localparam int POS_MODEM_LO = 16;
   localparam int POS_RX_AVAIL = 11;
   localparam int POS_RX_HALF = 10;
   localparam int POS_RX_FULL = 8;
   localparam int POS_TX_AVAIL = 3;
   localparam int POS_TX_HALF = 2;
   localparam int POS_TX_EMPTY = 0;

   // Status register B fields
   localparam int POS_FRAME_STAT_LO = 16;
   localparam int POS_TX_STAT_LO = 14;

   // ************************************************************
   // Sticky flags: index and bit position in status A
   // ************************************************************
   localparam int N_STICKY = 8;
   localparam int STK_PARITY = 0;
   localparam int STK_OVERRUN = 1;
   localparam int STK_RX_CLOSED = 2;
   localparam int STK_CARRIER = 3;
   localparam int STK_RING = 4;
   localparam int STK_SET_READY = 5;
   localparam int STK_CLEAR_SEND = 6;
   localparam int STK_TX_CLOSED = 7;
   localparam int STICKY_POS [0:7] = '{13, 12, 9, 7, 6, 5, 4, 1};

   // ************************************************************
   // Levels and reset values
   // ************************************************************
   localparam logic [5:0] HALF_LEVEL = 6'h10;
   localparam logic [5:0] COUNT_ZERO = 6'h00;

   typedef enum logic [1:0] {
      SFL_MODE_UART = 2'b00,
      SFL_MODE_HDLC = 2'b01,
      SFL_MODE_SPI_MASTER = 2'b10,
      SFL_MODE_SPI_SLAVE = 2'b11
   } sfl_mode_t;

   typedef struct packed {
      logic irq_en;
      sfl_mode_t mode;
      logic rx_dma;
      logic tx_dma;
      logic [7:0] sticky;
      logic [3:0] modem_prev;
      logic primed;
      logic [5:0] line_stat;
      logic [9:0] frame_stat;
      logic [1:0] tx_stat;
      logic [15:0] rx_desc;
      logic rx_desc_wr;
      logic [1:0] tx_desc;
      logic tx_desc_wr;
      logic rd_loaded;
      logic [31:0] prdata;
      logic slverr;
   } sfl_state_t;

   localparam sfl_state_t STATE_RESET = '0;

endpackage

// *** verification/sfl_status_tb.sv ***
`timescale 1ns/1ps
module testbench;
   // ************************************************************
   // Signals
   // ************************************************************
   logic mclk, rst, ce, psel, penable, pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic pready, pslverr;
   logic rx_parity_evt, rx_store_evt, rx_close_evt, rx_fifo_full, tx_close_evt, tx_fifo_empty;
   logic [5:0] rx_fifo_count, rx_line_status, tx_fifo_room;
   logic [2:0] rx_word_bytes;
   logic [9:0] rx_frame_status;
   logic [1:0] tx_frame_status, tx_desc_status;
   logic [3:0] modem;
   logic rx_data_avail, tx_space_avail, irq, rx_desc_wr, tx_desc_wr;
   logic [15:0] rx_desc_status;
   logic [31:0] rd, bit_m;
   logic er;
   int n_errors = 0;
   int checks_done = 0;
   int cycles = 0;
   int vals [0:3] = '{0, 15, 16, 32};
   int c;

   sfl_status i_sfl_status (.mclk(mclk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rx_parity_evt(rx_parity_evt), .rx_store_evt(rx_store_evt),
      .rx_close_evt(rx_close_evt), .rx_fifo_full(rx_fifo_full), .rx_fifo_count(rx_fifo_count),
      .rx_word_bytes(rx_word_bytes), .rx_line_status(rx_line_status), .rx_frame_status(rx_frame_status),
      .tx_close_evt(tx_close_evt), .tx_fifo_empty(tx_fifo_empty), .tx_fifo_room(tx_fifo_room),
      .tx_frame_status(tx_frame_status), .modem_carrier(modem[0]), .modem_ring(modem[1]),
      .modem_set_ready(modem[2]), .modem_clear_send(modem[3]), .rx_data_avail(rx_data_avail),
      .tx_space_avail(tx_space_avail), .irq(irq), .rx_desc_status(rx_desc_status),
      .rx_desc_wr(rx_desc_wr), .tx_desc_status(tx_desc_status), .tx_desc_wr(tx_desc_wr));

   initial mclk = 1'b0;
   always #12.5 mclk = ~mclk;

   // ************************************************************
   // Closing report and hang guard
   // ************************************************************
   task automatic stop_test();
      $display("errors %0d, comparisons %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_errors++;
         $display("wrong value at %0t: run did not finish", $time);
         stop_test();
      end
   end

   // ************************************************************
   // APB master; pe raises parity and close events during the access phase
   // ************************************************************
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic pe,
                      output logic [31:0] rdat, output logic err);
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      rx_parity_evt <= pe;
      rx_close_evt <= pe;
      do
         @(posedge mclk);
      while (pready !== 1'b1);
      rdat = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      rx_parity_evt <= 1'b0;
      rx_close_evt <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 1'b0, rd, er);
   endtask

   task automatic check_reg(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000, 1'b0, rd, er);
      checks_done++;
      if ((rd & m) !== (exp & m) || er !== 1'b0)
      begin
         n_errors++;
         $display("wrong value at %0t: read %h at %h, expected %h mask %h", $time, rd, a, exp, m);
      end
   endtask

   task automatic check_bit(input logic got, input logic exp, input string what);
      checks_done++;
      if (got !== exp)
      begin
         n_errors++;
         $display("wrong value at %0t: %s is %b", $time, what, got);
      end
   endtask

   task automatic check_err(input logic [11:0] a, input logic exp);
      apb(1'b0, a, 32'h0000_0000, 1'b0, rd, er);
      checks_done++;
      if (er !== exp || (exp === 1'b1 && rd !== 32'h0000_0000))
      begin
         n_errors++;
         $display("wrong value at %0t: error response %b at %h", $time, er, a);
      end
   endtask

   // One cycle event, indexed like the sticky flags
   task automatic pulse(input int k);
      @(posedge mclk);
      case (k)
         0: rx_parity_evt <= 1'b1;
         1: rx_store_evt <= 1'b1;
         2: rx_close_evt <= 1'b1;
         7: tx_close_evt <= 1'b1;
         default: modem[k-3] <= ~modem[k-3];
      endcase
      @(posedge mclk);
      rx_store_evt <= 1'b0;
      rx_close_evt <= 1'b0;
      tx_close_evt <= 1'b0;
      rx_parity_evt <= 1'b0;
   endtask

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial
   begin
      {rst, ce} = 2'b11;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {rx_parity_evt, rx_store_evt, rx_close_evt, rx_fifo_full, tx_close_evt} = '0;
      {rx_fifo_count, tx_fifo_room, modem} = '0;
      tx_fifo_empty = 1'b1;
      rx_word_bytes = 3'h4;
      rx_line_status = 6'h2D;
      rx_frame_status = 10'h3A5;
      tx_frame_status = 2'h2;
      repeat (6) @(posedge mclk);
      rst <= 1'b0;
      check_reg(sfl_pkg::CTRL_OFF, 32'hFFFF_FFFF, 32'h0000_0000);
      check_reg(sfl_pkg::STATUS_A_OFF, 32'hFFFF_FFFF, 32'h0000_0001);
      // Tx close outside HDLC and a store into a FIFO with room set nothing
      pulse(7);
      pulse(1);
      check_reg(sfl_pkg::STATUS_A_OFF, 32'h0000_1002, 32'h0000_0000);
      wr(sfl_pkg::CTRL_OFF, 32'h0000_0003);
      @(posedge mclk);
      rx_fifo_full <= 1'b1;
      for (int k = 0; k < sfl_pkg::N_STICKY; k++)
      begin
         bit_m = 32'h0000_0001 << sfl_pkg::STICKY_POS[k];
         pulse(k);
         @(posedge mclk);
         check_bit(irq, 1'b1, "irq after event");
         check_reg(sfl_pkg::STATUS_A_OFF, bit_m, bit_m);
         if (k == 3)
            check_reg(sfl_pkg::STATUS_A_OFF, 32'h000F_0000, 32'h0008_0000);
         if (k == 2)
         begin
            check_reg(sfl_pkg::STATUS_A_OFF, 32'hFC00_0000, 32'hB400_0000);
            check_reg(sfl_pkg::STATUS_B_OFF, 32'h03FF_0000, 32'h03A5_0000);
         end
         if (k == 7)
            check_reg(sfl_pkg::STATUS_B_OFF, 32'h0000_C000, 32'h0000_8000);
         rx_fifo_count <= 6'h04;
         tx_fifo_room <= 6'h04;
         wr(sfl_pkg::STATUS_A_OFF, 32'h0000_0000);
         check_reg(sfl_pkg::STATUS_A_OFF, bit_m, bit_m);
         if (k == 2)
            check_bit(rx_data_avail, 1'b0, "rx avail while closed");
         if (k == 7)
            check_bit(tx_space_avail, 1'b0, "tx avail while closed");
         wr(sfl_pkg::STATUS_A_OFF, bit_m);
         @(posedge mclk);
         check_bit(rx_data_avail, 1'b1, "rx avail after ack");
         check_bit(tx_space_avail, 1'b1, "tx avail after ack");
         rx_fifo_count <= 6'h00;
         tx_fifo_room <= 6'h00;
         check_reg(sfl_pkg::STATUS_A_OFF, bit_m, 32'h0000_0000);
         check_bit(irq, 1'b0, "irq after clear");
      end
      check_reg(sfl_pkg::STATUS_A_OFF, 32'h000F_0000, 32'h000F_0000);
      // Interrupt enable off masks a pending flag
      pulse(0);
      wr(sfl_pkg::CTRL_OFF, 32'h0000_0002);
      @(posedge mclk);
      check_bit(irq, 1'b0, "irq with enable off");
      // A new event in the very cycle of the clear survives
      apb(1'b1, sfl_pkg::STATUS_A_OFF, 32'h0000_2200, 1'b1, rd, er);
      check_reg(sfl_pkg::STATUS_A_OFF, 32'h0000_2200, 32'h0000_2200);
      wr(sfl_pkg::STATUS_A_OFF, 32'h0000_2200);
      // An event while the enable is low is not taken
      ce <= 1'b0;
      pulse(0);
      ce <= 1'b1;
      check_reg(sfl_pkg::STATUS_A_OFF, 32'h0000_2000, 32'h0000_0000);
      // Level flags at the boundaries of the counts
      for (int i = 0; i < 4; i++)
      begin
         c = vals[i];
         rx_fifo_count <= 6'(c);
         tx_fifo_room <= 6'(c);
         rx_fifo_full <= i[1];
         tx_fifo_empty <= i[0];
         bit_m = {20'h0_0000, c != 0, c >= 16, 1'b0, i[1], 4'h0, c != 0, c >= 16, 1'b0, i[0]};
         check_reg(sfl_pkg::STATUS_A_OFF, 32'h0000_0D0D, bit_m);
         check_bit(rx_data_avail, c != 0, "rx avail level");
      end
      for (int b = 1; b <= 4; b++)
      begin
         rx_word_bytes <= 3'(b);
         check_reg(sfl_pkg::STATUS_A_OFF, 32'h0030_0000, 32'(b % 4) << 20);
      end
      // Receive and transmit DMA auto acknowledge with descriptor write
      wr(sfl_pkg::CTRL_OFF, 32'h0000_0009);
      pulse(2);
      #1;
      check_bit(rx_desc_wr, 1'b1, "rx descriptor write");
      check_bit(rx_desc_status === 16'hB7A5, 1'b1, "rx descriptor status");
      @(posedge mclk);
      #1;
      check_bit(rx_desc_wr, 1'b0, "rx descriptor write end");
      check_reg(sfl_pkg::STATUS_A_OFF, 32'h0000_0A00, 32'h0000_0800);
      wr(sfl_pkg::CTRL_OFF, 32'h0000_0013);
      pulse(7);
      #1;
      check_bit(tx_desc_wr, 1'b1, "tx descriptor write");
      check_bit(tx_desc_status === 2'h2, 1'b1, "tx descriptor status");
      check_reg(sfl_pkg::STATUS_A_OFF, 32'h0000_000A, 32'h0000_0008);
      check_err(12'h004, 1'b1);
      check_err(sfl_pkg::STATUS_A_OFF, 1'b0);
      stop_test();
   end
endmodule

// *** verilog/sfl_status.sv ***
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/1ps
module sfl_status (
   // Clock, reset, enable
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Receive side
   input wire logic rx_parity_evt,
   input wire logic rx_store_evt,
   input wire logic rx_close_evt,
   input wire logic rx_fifo_full,
   input wire logic [5:0] rx_fifo_count,
   input wire logic [2:0] rx_word_bytes,
   input wire logic [5:0] rx_line_status,
   input wire logic [9:0] rx_frame_status,
   // Transmit side
   input wire logic tx_close_evt,
   input wire logic tx_fifo_empty,
   input wire logic [5:0] tx_fifo_room,
   input wire logic [1:0] tx_frame_status,
   // Modem lines
   input wire logic modem_carrier,
   input wire logic modem_ring,
   input wire logic modem_set_ready,
   input wire logic modem_clear_send,
   // Flags and descriptor status
   output logic rx_data_avail,
   output logic tx_space_avail,
   output logic irq,
   output logic [15:0] rx_desc_status,
   output logic rx_desc_wr,
   output logic [1:0] tx_desc_status,
   output logic tx_desc_wr
);

   // ************************************************************
   // Decoding helpers
   // ************************************************************
   // Four valid bytes wrap to code zero
   function automatic logic [1:0] byte_code(input logic [2:0] n);
      return n[1:0];
   endfunction

   function automatic logic hits(input logic [11:0] a, input logic [11:0] off);
      return a == off;
   endfunction

   sfl_pkg::sfl_state_t st_q;
   sfl_pkg::sfl_state_t st_d;
   logic [3:0] modem_now;
   logic rx_half;
   logic tx_half;
   logic acc;
   logic wr_ctrl;
   logic wr_stat_a;
   logic [7:0] set_v;
   logic [7:0] clr_v;
   logic [31:0] stat_a;
   logic [31:0] stat_b;
   logic [31:0] rd_word;
   logic rd_hit;

   assign modem_now = {modem_clear_send, modem_set_ready, modem_ring, modem_carrier};

   // ************************************************************
   // Live flags
   // ************************************************************
   assign rx_half = rx_fifo_count >= sfl_pkg::HALF_LEVEL;
   assign tx_half = tx_fifo_room >= sfl_pkg::HALF_LEVEL;
   // Closed flag gates readiness so firmware sees frame status first
   assign rx_data_avail = (rx_fifo_count != sfl_pkg::COUNT_ZERO) & ~st_q.sticky[sfl_pkg::STK_RX_CLOSED];
   assign tx_space_avail = (tx_fifo_room != sfl_pkg::COUNT_ZERO) & ~st_q.sticky[sfl_pkg::STK_TX_CLOSED];

   // ************************************************************
   // APB handshake
   // ************************************************************
   // A setup cycle with ce low costs one wait state
   assign pready = psel & penable & ce & st_q.rd_loaded;
   assign acc = pready;
   assign pslverr = pready & st_q.slverr;
   assign prdata = st_q.prdata;
   assign wr_ctrl = acc & pwrite & hits(paddr, sfl_pkg::CTRL_OFF);
   assign wr_stat_a = acc & pwrite & hits(paddr, sfl_pkg::STATUS_A_OFF);

   // ************************************************************
   // Status words
   // ************************************************************
   always_comb
   begin
      stat_a = sfl_pkg::WORD_ZERO;
      stat_a[sfl_pkg::POS_LINE_STAT_LO +: 6] = st_q.line_stat;
      stat_a[sfl_pkg::POS_BYTE_CNT_LO +: 2] = byte_code(rx_word_bytes);
      // Live lines read back with carrier on top and clear-to-send lowest
      stat_a[sfl_pkg::POS_MODEM_LO +: 4] = {modem_carrier, modem_ring, modem_set_ready, modem_clear_send};
      stat_a[sfl_pkg::POS_RX_AVAIL] = rx_data_avail;
      stat_a[sfl_pkg::POS_RX_HALF] = rx_half;
      stat_a[sfl_pkg::POS_RX_FULL] = rx_fifo_full;
      stat_a[sfl_pkg::POS_TX_AVAIL] = tx_space_avail;
      stat_a[sfl_pkg::POS_TX_HALF] = tx_half;
      stat_a[sfl_pkg::POS_TX_EMPTY] = tx_fifo_empty;
      for (int i = 0; i < sfl_pkg::N_STICKY; i++)
      begin
         stat_a[sfl_pkg::STICKY_POS[i]] = st_q.sticky[i];
      end
      stat_b = sfl_pkg::WORD_ZERO;
      stat_b[sfl_pkg::POS_FRAME_STAT_LO +: 10] = st_q.frame_stat;
      stat_b[sfl_pkg::POS_TX_STAT_LO +: 2] = st_q.tx_stat;
   end

   always_comb
   begin
      rd_word = sfl_pkg::WORD_ZERO;
      rd_hit = 1'b1;
      if (hits(paddr, sfl_pkg::CTRL_OFF))
      begin
         rd_word[sfl_pkg::CTL_IRQ_EN] = st_q.irq_en;
         rd_word[sfl_pkg::CTL_MODE_LO +: 2] = st_q.mode;
         rd_word[sfl_pkg::CTL_RX_DMA] = st_q.rx_dma;
         rd_word[sfl_pkg::CTL_TX_DMA] = st_q.tx_dma;
      end
      else if (hits(paddr, sfl_pkg::STATUS_A_OFF))
      begin
         rd_word = stat_a;
      end
      else if (hits(paddr, sfl_pkg::STATUS_B_OFF))
      begin
         rd_word = stat_b;
      end
      else
      begin
         rd_hit = 1'b0;
      end
   end

   // ************************************************************
   // Flag set and clear vectors
   // ************************************************************
   always_comb
   begin
      set_v = '0;
      set_v[sfl_pkg::STK_PARITY] = rx_parity_evt;
      set_v[sfl_pkg::STK_OVERRUN] = rx_store_evt & rx_fifo_full;
      set_v[sfl_pkg::STK_RX_CLOSED] = rx_close_evt;
      // First cycle after reset only primes the line history
      set_v[sfl_pkg::STK_CARRIER] = st_q.primed & (modem_now[0] ^ st_q.modem_prev[0]);
      set_v[sfl_pkg::STK_RING] = st_q.primed & (modem_now[1] ^ st_q.modem_prev[1]);
      set_v[sfl_pkg::STK_SET_READY] = st_q.primed & (modem_now[2] ^ st_q.modem_prev[2]);
      set_v[sfl_pkg::STK_CLEAR_SEND] = st_q.primed & (modem_now[3] ^ st_q.modem_prev[3]);
      set_v[sfl_pkg::STK_TX_CLOSED] = tx_close_evt & (st_q.mode == sfl_pkg::SFL_MODE_HDLC);
      clr_v = '0;
      for (int i = 0; i < sfl_pkg::N_STICKY; i++)
      begin
         clr_v[i] = wr_stat_a & pwdata[sfl_pkg::STICKY_POS[i]];
      end
      // DMA acknowledges the closed flags one cycle after they rise
      clr_v[sfl_pkg::STK_RX_CLOSED] = clr_v[sfl_pkg::STK_RX_CLOSED] | st_q.rx_dma;
      clr_v[sfl_pkg::STK_TX_CLOSED] = clr_v[sfl_pkg::STK_TX_CLOSED] | st_q.tx_dma;
   end

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb
   begin
      st_d = st_q;
      if (ce)
      begin
         st_d.rx_desc_wr = 1'b0;
         st_d.tx_desc_wr = 1'b0;
         st_d.modem_prev = modem_now;
         st_d.primed = 1'b1;
         for (int i = 0; i < sfl_pkg::N_STICKY; i++)
         begin
            st_d.sticky[i] = set_v[i] | (st_q.sticky[i] & ~clr_v[i]);
         end
         if (rx_close_evt)
         begin
            st_d.line_stat = rx_line_status;
            st_d.frame_stat = rx_frame_status;
            if (st_q.rx_dma)
            begin
               st_d.rx_desc = {rx_line_status, rx_frame_status};
               st_d.rx_desc_wr = 1'b1;
            end
         end
         if (set_v[sfl_pkg::STK_TX_CLOSED])
         begin
            st_d.tx_stat = tx_frame_status;
            if (st_q.tx_dma)
            begin
               st_d.tx_desc = tx_frame_status;
               st_d.tx_desc_wr = 1'b1;
            end
         end
         if (wr_ctrl)
         begin
            st_d.irq_en = pwdata[sfl_pkg::CTL_IRQ_EN];
            st_d.mode = sfl_pkg::sfl_mode_t'(pwdata[sfl_pkg::CTL_MODE_LO +: 2]);
            st_d.rx_dma = pwdata[sfl_pkg::CTL_RX_DMA];
            st_d.tx_dma = pwdata[sfl_pkg::CTL_TX_DMA];
         end
         if (psel & ~st_q.rd_loaded)
         begin
            st_d.prdata = rd_word;
            st_d.slverr = ~rd_hit;
            st_d.rd_loaded = 1'b1;
         end
         else if (acc)
         begin
            st_d.rd_loaded = 1'b0;
         end
      end
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         st_q <= sfl_pkg::STATE_RESET;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   // One request line: every sticky flag and the avail and half flags under the enable, not the full or empty flags
   assign irq = st_q.irq_en & ((|st_q.sticky) | rx_data_avail | rx_half | tx_space_avail | tx_half);
   assign rx_desc_status = st_q.rx_desc;
   assign rx_desc_wr = st_q.rx_desc_wr;
   assign tx_desc_status = st_q.tx_desc;
   assign tx_desc_wr = st_q.tx_desc_wr;

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   sequence s_rx_close_dma;
      ce && rx_close_evt && st_q.rx_dma;
   endsequence

   sequence s_quiet_rx;
      ce && !rx_close_evt;
   endsequence

   sequence s_tx_close_dma;
      ce && tx_close_evt && st_q.mode == sfl_pkg::SFL_MODE_HDLC && st_q.tx_dma;
   endsequence

   sequence s_quiet_tx;
      ce && !tx_close_evt && st_q.tx_dma;
   endsequence

   property p_parity_set;
      ce && rx_parity_evt |=> st_q.sticky[sfl_pkg::STK_PARITY] && stat_a[13];
   endproperty
   a_parity_set: assert property (p_parity_set) else $error("parity flag not set");

   property p_parity_hold;
      ce && st_q.sticky[sfl_pkg::STK_PARITY] && !(wr_stat_a && pwdata[13]) |=> st_q.sticky[sfl_pkg::STK_PARITY];
   endproperty
   a_parity_hold: assert property (p_parity_hold) else $error("parity flag lost without clear");

   property p_overrun;
      ce && rx_store_evt && rx_fifo_full |=> st_q.sticky[sfl_pkg::STK_OVERRUN];
   endproperty
   a_overrun: assert property (p_overrun) else $error("overrun flag not set");

   property p_rx_interlock;
      st_q.sticky[sfl_pkg::STK_RX_CLOSED] |-> !rx_data_avail;
   endproperty
   a_rx_interlock: assert property (p_rx_interlock) else $error("rx available while closed");

   property p_rx_dma_ack;
      s_rx_close_dma ##1 s_quiet_rx |=> !st_q.sticky[sfl_pkg::STK_RX_CLOSED];
   endproperty
   a_rx_dma_ack: assert property (p_rx_dma_ack) else $error("rx closed not auto acknowledged");

   property p_rx_desc;
      s_rx_close_dma |=> rx_desc_wr && rx_desc_status[15:10] == $past(rx_line_status);
   endproperty
   a_rx_desc: assert property (p_rx_desc) else $error("rx descriptor status not written");

   property p_frame_latch;
      ce && rx_close_evt |=> stat_b[25:16] == $past(rx_frame_status);
   endproperty
   a_frame_latch: assert property (p_frame_latch) else $error("frame status not latched");

   property p_modem_change;
      ce && st_q.primed && (modem_carrier != st_q.modem_prev[0]) |=> st_q.sticky[sfl_pkg::STK_CARRIER];
   endproperty
   a_modem_change: assert property (p_modem_change) else $error("carrier change flag not set");

   property p_cts_change;
      ce && st_q.primed && $changed(modem_clear_send) |=> st_q.sticky[sfl_pkg::STK_CLEAR_SEND];
   endproperty
   a_cts_change: assert property (p_cts_change) else $error("clear send change flag not set");

   property p_tx_interlock;
      st_q.sticky[sfl_pkg::STK_TX_CLOSED] |-> !tx_space_avail && !stat_a[3];
   endproperty
   a_tx_interlock: assert property (p_tx_interlock) else $error("tx ready while closed");

   property p_set_wins;
      ce && rx_close_evt && wr_stat_a && pwdata[9] |=> st_q.sticky[sfl_pkg::STK_RX_CLOSED];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("clear beat a set");

   property p_half_levels;
      (stat_a[10] == (rx_fifo_count >= 6'h10)) && (stat_a[2] == (tx_fifo_room >= 6'h10));
   endproperty
   a_half_levels: assert property (p_half_levels) else $error("half flag level wrong");

   property p_overrun_only_full;
      ce && rx_store_evt && !rx_fifo_full && !st_q.sticky[sfl_pkg::STK_OVERRUN] |=> !st_q.sticky[sfl_pkg::STK_OVERRUN];
   endproperty
   a_overrun_only_full: assert property (p_overrun_only_full) else $error("overrun set with room left");

   property p_ring_change;
      ce && st_q.primed && (modem_ring != st_q.modem_prev[1]) |=> st_q.sticky[sfl_pkg::STK_RING];
   endproperty
   a_ring_change: assert property (p_ring_change) else $error("ring change flag not set");

   property p_dsr_change;
      ce && st_q.primed && (modem_set_ready != st_q.modem_prev[2]) |=> st_q.sticky[sfl_pkg::STK_SET_READY];
   endproperty
   a_dsr_change: assert property (p_dsr_change) else $error("set ready change flag not set");

   property p_tx_desc;
      s_tx_close_dma |=> tx_desc_wr && tx_desc_status == $past(tx_frame_status);
   endproperty
   a_tx_desc: assert property (p_tx_desc) else $error("tx descriptor status not written");

   // Acknowledge follows the close by one cycle, so firmware never has to
   property p_tx_dma_ack;
      s_tx_close_dma ##1 s_quiet_tx |=> !st_q.sticky[sfl_pkg::STK_TX_CLOSED];
   endproperty
   a_tx_dma_ack: assert property (p_tx_dma_ack) else $error("tx closed not auto acknowledged");

endmodule
